// [nnpe_defines.vh]
// constants for the negate / no-op / pop execution block
// What this block does
// - negate writes two's complement of file register, sets negative, wrap, carry, nibble carry, zero
// - access bit zero maps address into access bank; one uses bank select
// - extended set, access zero, address at most 5Fh: indexed literal offset addressing
// - all-zero word or top nibble 1111 is a no-op changing nothing
// - pop word discards stack head in third phase; next entry becomes head
`ifndef NNPE_DEFINES_VH
`define NNPE_DEFINES_VH
`define NNPE_NEG_OPC       7'h36
`define NNPE_NEG_OPC_HI    15
`define NNPE_NEG_OPC_LO    9
`define NNPE_ACC_BIT       8
`define NNPE_NOP_ZERO      16'h0000
`define NNPE_NOP_NIB       4'hF
`define NNPE_POP_WORD      16'h0006
`define NNPE_IDX_MAX       8'h5F
`define NNPE_ACC_SPLIT     8'h60
`define NNPE_ACC_HI_BANK   4'hF
`define NNPE_STK_DEPTH     31
`define NNPE_PTR_W         5
`define NNPE_PTR_FULL      5'h1F
`define NNPE_PC_W          21
`define NNPE_Q1            2'd0
`define NNPE_Q2            2'd1
`define NNPE_Q3            2'd2
`define NNPE_Q4            2'd3
`define NNPE_FLAG_N        4
`define NNPE_FLAG_WRAP     3
`define NNPE_FLAG_Z        2
`define NNPE_FLAG_NIB      1
`define NNPE_FLAG_C        0
`endif

// [nnpe_neg_alu.v]
// combinational two's complement negate with status flags
`timescale 1ns/100ps
`default_nettype none
`include "nnpe_defines.vh"
module nnpe_neg_alu (
   input  wire [7:0] operand,
   output wire [7:0] result,
   output wire [4:0] flags
);
   wire [8:0] full_sum;
   wire [4:0] low_sum;
   // negate as ~f + 1 so carry and nibble carry follow the adder
   assign full_sum = {1'b0, ~operand} + 9'h001;
   assign low_sum  = {1'b0, ~operand[3:0]} + 5'h01;
   assign result   = full_sum[7:0];
   assign flags[`NNPE_FLAG_N]    = full_sum[7];
   assign flags[`NNPE_FLAG_WRAP] = operand[7] & full_sum[7];
   assign flags[`NNPE_FLAG_Z]    = (full_sum[7:0] == 8'h00);
   assign flags[`NNPE_FLAG_NIB]  = low_sum[4];
   assign flags[`NNPE_FLAG_C]    = full_sum[8];
endmodule
`default_nettype wire

// [nnpe_exec.v]
// execution of negate, no-op and pop instructions over four Q phases
`timescale 1ns/100ps
`default_nettype none
`include "nnpe_defines.vh"
module nnpe_exec (
   input  wire                    sys_clk,
   input  wire                    srst,
   input  wire                    clk_en,
   input  wire                    instr_valid,
   input  wire [15:0]             instr_word,
   input  wire                    ext_set_en,
   input  wire [3:0]              bank_select_reg,
   input  wire [11:0]             idx_base,
   input  wire [7:0]              file_rd_data,
   input  wire [4:0]              status_in,
   input  wire [`NNPE_PC_W-1:0]   stack_push_data,
   input  wire                    stack_push,
   output reg  [1:0]              q_phase_ff,
   output reg  [11:0]             file_addr_ff,
   output reg                     file_rd_ff,
   output reg                     file_wr_ff,
   output reg  [7:0]              file_wr_data_ff,
   output reg                     status_wr_ff,
   output reg  [4:0]              status_out_ff,
   output reg  [`NNPE_PC_W-1:0]   return_stack_head_ff,
   output reg  [`NNPE_PTR_W-1:0]  stack_ptr_ff,
   output reg                     stack_underflow_ff,
   output reg                     instr_done_ff
);
   localparam OP_NONE = 2'd0;
   localparam OP_NEG  = 2'd1;
   localparam OP_NOP  = 2'd2;
   localparam OP_POP  = 2'd3;

   ////////////////////////////////////////////////////////////////////
   reg [1:0]              op_ff;
   reg [7:0]              operand_ff;
   reg [7:0]              result_ff;
   reg [4:0]              flags_ff;
   reg [`NNPE_PC_W-1:0]   stack_mem [0:`NNPE_STK_DEPTH-1];
   reg [1:0]              nxt_op;
   reg [11:0]             nxt_addr;
   wire [7:0]             neg_result;
   wire [4:0]             neg_flags;
   reg [1:0]              nxt_phase;
   reg [`NNPE_PTR_W-1:0]  nxt_ptr;
   reg [`NNPE_PC_W-1:0]   nxt_head;
   reg                    nxt_underflow;
   wire                   take;
   wire                   push_go;
   wire                   pop_go;

   // file address generation for the negate operand
   function [11:0] map_addr;
      input [7:0]  f;
      input        a;
      input        ext;
      input [3:0]  bank;
      input [11:0] base;
      begin
         if (a)
            map_addr = {bank, f};
         else if (ext && (f <= `NNPE_IDX_MAX))
            map_addr = base + {4'h0, f};
         else if (f < `NNPE_ACC_SPLIT)
            map_addr = {4'h0, f};
         else
            map_addr = {`NNPE_ACC_HI_BANK, f};
      end
   endfunction

   // stack pointer arithmetic shared by push and pop
   function [`NNPE_PTR_W-1:0] ptr_step;
      input [`NNPE_PTR_W-1:0] ptr;
      input                   up;
      begin
         if (up)
            ptr_step = ptr + 5'd1;
         else
            ptr_step = ptr - 5'd1;
      end
   endfunction

   nnpe_neg_alu u_alu (
      .operand (operand_ff),
      .result  (neg_result),
      .flags   (neg_flags)
   );

   ////////////////////////////////////////////////////////////////////
   always @* begin
      nxt_op = OP_NONE;
      if (instr_word == `NNPE_POP_WORD)
         nxt_op = OP_POP;
      else if (instr_word == `NNPE_NOP_ZERO || instr_word[15:12] == `NNPE_NOP_NIB)
         nxt_op = OP_NOP;
      else if (instr_word[`NNPE_NEG_OPC_HI:`NNPE_NEG_OPC_LO] == `NNPE_NEG_OPC)
         nxt_op = OP_NEG;
      nxt_addr = map_addr(instr_word[7:0], instr_word[`NNPE_ACC_BIT], ext_set_en,
                          bank_select_reg, idx_base);
   end

   ////////////////////////////////////////////////////////////////////
   // only a Q1 edge that the enable lets through takes a word
   assign take    = clk_en && (q_phase_ff == `NNPE_Q1) && instr_valid;
   // pushes wait for an idle Q2, so they never race a pop
   assign push_go = clk_en && (q_phase_ff == `NNPE_Q2) && (op_ff == OP_NONE) && stack_push;
   assign pop_go  = clk_en && (q_phase_ff == `NNPE_Q3) && (op_ff == OP_POP);

   always @* begin
      nxt_phase = q_phase_ff;
      if (clk_en)
         nxt_phase = q_phase_ff + 2'd1;
   end

   ////////////////////////////////////////////////////////////////////
   // unrecognised words still take a cycle but, unlike a no-op, raise no done pulse in Q4
   always @(posedge sys_clk) begin
      if (srst) begin
         q_phase_ff <= `NNPE_Q1;
         op_ff      <= OP_NONE;
      end else begin
         q_phase_ff <= nxt_phase;
         if (take)
            op_ff <= nxt_op;
         else if (clk_en && q_phase_ff == `NNPE_Q1)
            op_ff <= OP_NONE;
      end
   end

   ////////////////////////////////////////////////////////////////////
   always @* begin
      nxt_ptr       = stack_ptr_ff;
      nxt_head      = return_stack_head_ff;
      nxt_underflow = stack_underflow_ff;
      if (push_go) begin
         // a full stack keeps its depth and only the head is replaced
         if (stack_ptr_ff != `NNPE_PTR_FULL)
            nxt_ptr = ptr_step(stack_ptr_ff, 1'b1);
         nxt_head = stack_push_data;
      end else if (pop_go) begin
         if (stack_ptr_ff != {`NNPE_PTR_W{1'b0}}) begin
            nxt_ptr  = ptr_step(stack_ptr_ff, 1'b0);
            nxt_head = stack_mem[ptr_step(stack_ptr_ff, 1'b0)];
         end else begin
            // empty stack: head cleared, flag kept sticky until reset
            nxt_head      = {`NNPE_PC_W{1'b0}};
            nxt_underflow = 1'b1;
         end
      end
   end

   always @(posedge sys_clk) begin
      if (srst) begin
         return_stack_head_ff <= {`NNPE_PC_W{1'b0}};
         stack_ptr_ff         <= {`NNPE_PTR_W{1'b0}};
         stack_underflow_ff   <= 1'b0;
      end else if (clk_en) begin
         return_stack_head_ff <= nxt_head;
         stack_ptr_ff         <= nxt_ptr;
         stack_underflow_ff   <= nxt_underflow;
      end
   end

   // entries carry no reset; only slots below the pointer are ever read
   always @(posedge sys_clk) begin
      if (!srst && push_go && stack_ptr_ff != `NNPE_PTR_FULL)
         stack_mem[stack_ptr_ff] <= return_stack_head_ff;
   end

   ////////////////////////////////////////////////////////////////////
   always @(posedge sys_clk) begin
      if (srst) begin
         operand_ff      <= 8'h00;
         result_ff       <= 8'h00;
         flags_ff        <= 5'h00;
         file_addr_ff    <= 12'h000;
         file_rd_ff      <= 1'b0;
         file_wr_ff      <= 1'b0;
         file_wr_data_ff <= 8'h00;
         status_wr_ff    <= 1'b0;
         status_out_ff   <= 5'h00;
         instr_done_ff   <= 1'b0;
      end else if (clk_en) begin
         file_rd_ff    <= 1'b0;
         file_wr_ff    <= 1'b0;
         status_wr_ff  <= 1'b0;
         instr_done_ff <= 1'b0;
         case (q_phase_ff)
            `NNPE_Q1: begin
               if (take && nxt_op == OP_NEG) begin
                  file_addr_ff <= nxt_addr;
                  file_rd_ff   <= 1'b1;
               end
            end
            `NNPE_Q2: begin
               if (op_ff == OP_NEG)
                  operand_ff <= file_rd_data;
            end
            `NNPE_Q3: begin
               if (op_ff == OP_NEG) begin
                  result_ff <= neg_result;
                  flags_ff  <= neg_flags;
               end
            end
            `NNPE_Q4: begin
               instr_done_ff <= (op_ff != OP_NONE);
               if (op_ff == OP_NEG) begin
                  file_wr_ff      <= 1'b1;
                  file_wr_data_ff <= result_ff;
                  status_wr_ff    <= 1'b1;
                  status_out_ff   <= flags_ff;
               end else begin
                  // other words hand the flags on untouched
                  status_out_ff   <= status_in;
               end
            end
            default: begin
               file_rd_ff <= 1'b0;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// [nnpe_exec_properties.sv]
// assertions for the negate / no-op / pop execution block
`timescale 1ns/100ps
`default_nettype none
module nnpe_exec_properties (
   input wire logic        sys_clk,
   input wire logic        srst,
   input wire logic        clk_en,
   input wire logic        instr_valid,
   input wire logic [15:0] instr_word,
   input wire logic        ext_set_en,
   input wire logic [3:0]  bank_select_reg,
   input wire logic [11:0] idx_base,
   input wire logic [7:0]  file_rd_data,
   input wire logic [1:0]  q_phase_ff,
   input wire logic [11:0] file_addr_ff,
   input wire logic        file_rd_ff,
   input wire logic        file_wr_ff,
   input wire logic        status_wr_ff,
   input wire logic [7:0]  file_wr_data_ff,
   input wire logic [4:0]  status_out_ff,
   input wire logic [4:0]  stack_ptr_ff,
   input wire logic        instr_done_ff
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   wire take = clk_en && instr_valid && q_phase_ff == 2'd0;
   wire neg  = take && instr_word[15:9] == 7'h36;
   wire nop  = take && (instr_word == 16'h0000 || instr_word[15:12] == 4'hF);
   wire pop  = take && instr_word == 16'h0006;
   // access addresses from 60h up land in the top bank
   function automatic logic [11:0] f_addr(input logic [15:0] w, input logic e, input logic [3:0] b,
                                         input logic [11:0] s);
      if (w[8]) return {b, w[7:0]};
      if (e && w[7:0] <= 8'h5F) return s + {4'h0, w[7:0]};
      return {(w[7:0] < 8'h60) ? 4'h0 : 4'hF, w[7:0]};
   endfunction
////////////////////////////////////////////////////////////////////////////////
   a_neg_phases: assert property (neg |=> file_rd_ff ##3 (file_wr_ff && status_wr_ff && instr_done_ff))
      else $error("negate phase pulses out of step");
   a_neg_value: assert property (file_wr_ff |-> file_wr_data_ff == 8'h00 - $past(file_rd_data, 3))
      else $error("negate result wrong");
   a_nz_flags: assert property (file_wr_ff |-> status_out_ff[4] == file_wr_data_ff[7]
      && status_out_ff[2] == (file_wr_data_ff == 8'h00)) else $error("negative or zero flag wrong");
   a_addr_map: assert property (neg |=> file_addr_ff == f_addr($past(instr_word), $past(ext_set_en),
      $past(bank_select_reg), $past(idx_base))) else $error("file address mapping wrong");
   a_nop_quiet: assert property (nop |=> (!file_rd_ff && !file_wr_ff && !status_wr_ff)[*3]
      ##1 (instr_done_ff && !file_wr_ff)) else $error("no-op touched state");
   a_pop_third: assert property (pop && stack_ptr_ff != 5'h00 |-> ##2 $stable(stack_ptr_ff)
      ##1 stack_ptr_ff == $past(stack_ptr_ff) - 5'h01) else $error("pop not in third phase");
   a_freeze_hold: assert property (!clk_en |=> $stable(q_phase_ff) && $stable(file_rd_ff)
      && $stable(file_wr_ff) && $stable(stack_ptr_ff)) else $error("state moved while enable low");
   c_neg: cover property (neg ##4 file_wr_ff);
   c_freeze: cover property (!clk_en ##1 !clk_en);
   c_nop: cover property (nop);
   c_pop: cover property (pop && stack_ptr_ff != 5'h00);
endmodule
bind nnpe_exec nnpe_exec_properties i_nnpe_exec_properties (.*);
`default_nettype wire

// [negate_nop_pop_exec_bench.sv]
// self-checking bench for the negate / no-op / pop execution block
`timescale 1ns/100ps
`default_nettype none
module negate_nop_pop_exec_bench;
   logic        sys_clk = 1'b0, srst = 1'b1, clk_en = 1'b1, instr_valid = 1'b0, ext_set_en = 1'b0;
   logic        stack_push = 1'b0;
   logic [15:0] instr_word = 16'h0000;
   logic [3:0]  bank_select_reg = 4'h0;
   logic [11:0] idx_base = 12'h000;
   logic [7:0]  file_rd_data = 8'h00;
   logic [4:0]  status_in = 5'h1F;
   logic [20:0] stack_push_data = 21'h00_0000;
   wire  [1:0]  q_phase_ff;
   wire  [11:0] file_addr_ff;
   wire         file_rd_ff, file_wr_ff, status_wr_ff, stack_underflow_ff, instr_done_ff;
   wire  [7:0]  file_wr_data_ff;
   wire  [4:0]  status_out_ff, stack_ptr_ff;
   wire  [20:0] return_stack_head_ff;
   int          mismatches = 0;
   int          n_tests = 0;
   nnpe_exec i_nnpe_exec (.*);
   always #50 sys_clk = ~sys_clk;
////////////////////////////////////////////////////////////////////////////////
   task automatic close_out();
      if (mismatches == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("Error at %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic do_reset();
      @(posedge sys_clk) srst <= 1'b1;
      repeat (20) @(posedge sys_clk);
      srst <= 1'b0;
      #1;
   endtask
   // bounded: a phase counter that stalls ends the run
   task automatic wait_ph(input logic [1:0] p);
      for (int i = 0; i < 8 && q_phase_ff !== p; i++) @(posedge sys_clk) #1;
      if (q_phase_ff !== p) begin
         mismatches++;
         $display("Error at %0t phase %h expected %h", $time, q_phase_ff, p);
         close_out();
      end
   endtask
   // ef is {read, write, done}; ctx is {extended, bank, base}
   task automatic exec(input logic [16:0] ctx, input logic [15:0] w, input logic [7:0] d,
                       input logic [11:0] ea, input logic [2:0] ef, input logic [12:0] eds);
      wait_ph(2'd3);
      @(posedge sys_clk);
      {ext_set_en, bank_select_reg, idx_base} <= ctx;
      instr_valid  <= 1'b1;
      instr_word   <= w;
      file_rd_data <= d;
      @(posedge sys_clk) instr_valid <= 1'b0;
      #1 chk({file_rd_ff, ef[2] ? file_addr_ff : 12'h000}, {ef[2], ea});
      repeat (3) @(posedge sys_clk);
      #1 chk({file_wr_ff, status_wr_ff, instr_done_ff}, {ef[1], ef[1], ef[0]});
      if (ef[1]) chk({file_wr_data_ff, status_out_ff}, eds);
      else chk(status_out_ff, status_in);
   endtask
   task automatic push(input logic [20:0] v);
      wait_ph(2'd0);
      @(posedge sys_clk);
      stack_push      <= 1'b1;
      stack_push_data <= v;
      @(posedge sys_clk) stack_push <= 1'b0;
      #1;
   endtask
////////////////////////////////////////////////////////////////////////////////
   task automatic t_negate();
      exec(17'h0_3000, 16'h6D22, 8'h3A, 12'h322, 3'b111, {8'hC6, 5'h10});
      exec(17'h0_3000, 16'h6D22, 8'h80, 12'h322, 3'b111, {8'h80, 5'h1A});
      exec(17'h0_3000, 16'h6D22, 8'h00, 12'h322, 3'b111, {8'h00, 5'h07});
   endtask
   task automatic t_access();
      exec(17'h0_3000, 16'h6C20, 8'h05, 12'h020, 3'b111, {8'hFB, 5'h10});
      exec(17'h0_3000, 16'h6C80, 8'h05, 12'hF80, 3'b111, {8'hFB, 5'h10});
      exec(17'h1_3100, 16'h6C5F, 8'h05, 12'h15F, 3'b111, {8'hFB, 5'h10});
      exec(17'h1_3100, 16'h6C60, 8'h05, 12'hF60, 3'b111, {8'hFB, 5'h10});
      exec(17'h1_3100, 16'h6D10, 8'h05, 12'h310, 3'b111, {8'hFB, 5'h10});
   endtask
   task automatic t_nop();
      exec(17'h0_0000, 16'h0000, 8'h00, 12'h000, 3'b001, 13'h0000);
      exec(17'h0_0000, 16'hF123, 8'h00, 12'h000, 3'b001, 13'h0000);
      exec(17'h0_0000, 16'h1234, 8'h00, 12'h000, 3'b000, 13'h0000);
   endtask
   // a word offered while the enable is low must not be taken
   task automatic t_freeze();
      wait_ph(2'd3);
      @(posedge sys_clk);
      clk_en      <= 1'b0;
      instr_valid <= 1'b1;
      instr_word  <= 16'h6D22;
      repeat (3) @(posedge sys_clk);
      #1 chk({q_phase_ff, file_rd_ff, instr_done_ff}, 4'h0);
      @(posedge sys_clk);
      clk_en      <= 1'b1;
      instr_valid <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1 chk({q_phase_ff, file_rd_ff}, {2'd2, 1'b0});
   endtask
   task automatic t_pop();
      exec(17'h0_0000, 16'h0006, 8'h00, 12'h000, 3'b001, 13'h0000);
      chk({stack_underflow_ff, stack_ptr_ff, return_stack_head_ff}, {1'b1, 5'h00, 21'h00_0000});
      do_reset();
      push(21'h01_4332);
      push(21'h00_31A2);
      exec(17'h0_0000, 16'h0006, 8'h00, 12'h000, 3'b001, 13'h0000);
      chk({stack_underflow_ff, stack_ptr_ff, return_stack_head_ff}, {1'b0, 5'h01, 21'h01_4332});
   endtask
   initial begin
      do_reset();
      t_negate();
      t_access();
      t_nop();
      t_freeze();
      t_pop();
      close_out();
   end
endmodule
`default_nettype wire
